// file: logic/bin16_arith_move_unit.sv
`timescale 1ns/1ns

// Summary of operation
// - Two-operand add: destination plus source.
// - Three-operand add: source one plus two.
// - Operands are signed, bit 15 is sign.
// - Add and subtract wrap, no carry.
// - Two-operand subtract: destination minus source.
// - Three-operand subtract: source one minus two.
// - Multiply gives signed 32-bit product for words only.
// - Bit destination filled four bits per digit.
// - Quotient low; remainder high for words only.
// - Quotient and remainder both signed.
// - Error on zero divisor or bad destination.
// - Increment wraps maximum to most negative.
// - Decrement wraps most negative to maximum.
// - Increment and decrement by one in place.
// - Copy writes source unchanged to destination.
// - Written value held until next write.
// - Sign flip writes two's complement in place.
module bin16_arith_move_unit #(
    parameter int SLOTS = bin16_pkg::DEFAULT_SLOTS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Instruction request from the scanner
    input wire logic req_valid,
    input wire bin16_pkg::op_t req_op,
    input wire logic req_pulse,
    input wire logic req_cond,
    input wire logic [$clog2(SLOTS)-1:0] req_slot,
    // Operands
    input wire logic [15:0] src_one,
    input wire logic [15:0] src_two,
    input wire logic [15:0] dst_in,
    input wire bin16_pkg::dst_kind_t dst_kind,
    input wire logic [2:0] dst_digits,
    // Error flag control
    input wire logic error_clear,
    // Results
    output logic [15:0] result_lo,
    output logic [15:0] result_hi,
    output logic write_lo,
    output logic write_hi,
    output logic exec_done,
    output logic operation_error_flag
);

    // Every check below samples on the one clock and rests during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [SLOTS-1:0] prev_cond;
        logic [15:0] res_lo;
        logic [15:0] res_hi;
        logic wr_lo;
        logic wr_hi;
        logic done;
        logic err;
    } state_t;

    state_t st_q;
    state_t st_d;

    logic signed [15:0] quo;
    logic signed [15:0] rem;
    logic div_zero;
    logic fire;
    logic bad;
    logic [15:0] mask;
    logic [31:0] wide;
    logic two_halves;

    // ****************************************************************
    // Divider
    // ****************************************************************
    signed_div16 u_div (
        .dividend(src_one),
        .divisor(src_two),
        .quotient(quo),
        .remainder(rem),
        .div_zero(div_zero)
    );

    // ****************************************************************
    // Datapath
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        st_d.wr_lo = 1'b0;
        st_d.wr_hi = 1'b0;
        st_d.done = 1'b0;
        wide = {bin16_pkg::WORD_ZERO, bin16_pkg::WORD_ZERO};
        two_halves = 1'b0;
        mask = bin16_pkg::WORD_ALL;
        fire = 1'b0;
        bad = 1'b0;

        // Pulse forms need the condition of the previous scan per slot
        fire = req_valid && req_cond && (!req_pulse || !st_q.prev_cond[req_slot]);
        if (req_valid) begin
            st_d.prev_cond[req_slot] = req_cond;
        end

        // Wrapping 16-bit arithmetic except multiply and divide, which fill 32 bits; no carry is produced
        unique case (req_op)
            bin16_pkg::ADD_TWO_OP: wide[15:0] = dst_in + src_one;
            bin16_pkg::ADD_THREE_OP: wide[15:0] = src_one + src_two;
            bin16_pkg::SUB_TWO_OP: wide[15:0] = dst_in - src_one;
            bin16_pkg::SUB_THREE_OP: wide[15:0] = src_one - src_two;
            bin16_pkg::MUL_OP: begin
                wide = 32'($signed(src_one)) * 32'($signed(src_two));
                two_halves = 1'b1;
            end
            bin16_pkg::DIV_OP: begin
                wide = {rem, quo};
                two_halves = 1'b1;
            end
            bin16_pkg::ADD_ONE_OP: wide[15:0] = dst_in + bin16_pkg::WORD_ONE;
            bin16_pkg::SUB_ONE_OP: wide[15:0] = dst_in - bin16_pkg::WORD_ONE;
            bin16_pkg::COPY_WORD_OP: wide[15:0] = src_one;
            bin16_pkg::SIGN_FLIP_OP: wide[15:0] = bin16_pkg::WORD_ZERO - dst_in;
            default: wide = {bin16_pkg::WORD_ZERO, bin16_pkg::WORD_ZERO};
        endcase

        // Digit count outside one to four groups is not a legal destination
        if (dst_kind == bin16_pkg::DST_BITS) begin
            if (dst_digits < bin16_pkg::ONE_DIGIT_GROUP
                    || dst_digits > bin16_pkg::FOUR_DIGIT_GROUP) begin
                bad = 1'b1;
            end else begin
                mask = bin16_pkg::WORD_ALL >> (6'(bin16_pkg::WORD_W)
                    - 6'(dst_digits) * 6'(bin16_pkg::BITS_PER_DIGIT));
            end
        end
        if (dst_kind != bin16_pkg::DST_WORD && dst_kind != bin16_pkg::DST_BITS) begin
            bad = 1'b1;
        end
        if (req_op == bin16_pkg::DIV_OP && div_zero) begin
            bad = 1'b1;
        end

        if (error_clear) begin
            st_d.err = 1'b0;
        end
        if (fire) begin
            st_d.done = 1'b1;
            if (bad) begin
                // Set is written after clear so a new error is never lost
                st_d.err = 1'b1;
            end else if (dst_kind == bin16_pkg::DST_BITS) begin
                // Bits above the group keep their old value
                st_d.res_lo = (dst_in & ~mask) | (wide[15:0] & mask);
                st_d.wr_lo = 1'b1;
            end else begin
                st_d.res_lo = wide[15:0];
                st_d.wr_lo = 1'b1;
                if (two_halves) begin
                    st_d.res_hi = wide[31:16];
                    st_d.wr_hi = 1'b1;
                end
            end
        end
    end

    // Results hold between writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign result_lo = st_q.res_lo;
    assign result_hi = st_q.res_hi;
    assign write_lo = st_q.wr_lo;
    assign write_hi = st_q.wr_hi;
    assign exec_done = st_q.done;
    assign operation_error_flag = st_q.err;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic ok_word;
    assign ok_word = fire && !bad && dst_kind == bin16_pkg::DST_WORD;

    property p_add_two;
        ok_word && req_op == bin16_pkg::ADD_TWO_OP
            |=> write_lo && result_lo == 16'($past(dst_in) + $past(src_one));
    endproperty
    a_add_two: assert property (p_add_two) else $error("two-operand add wrong");

    property p_sub_three;
        ok_word && req_op == bin16_pkg::SUB_THREE_OP
            |=> write_lo && result_lo == 16'($past(src_one) - $past(src_two));
    endproperty
    a_sub_three: assert property (p_sub_three) else $error("three-operand sub wrong");

    property p_mul;
        ok_word && req_op == bin16_pkg::MUL_OP
            |=> write_hi && {result_hi, result_lo}
                == 32'($signed($past(src_one))) * 32'($signed($past(src_two)));
    endproperty
    a_mul: assert property (p_mul) else $error("product wrong");

    property p_bits_no_hi;
        fire && !bad && dst_kind == bin16_pkg::DST_BITS |=> write_lo && !write_hi;
    endproperty
    a_bits_no_hi: assert property (p_bits_no_hi) else $error("bit dest wrote high half");

    property p_div_zero;
        fire && req_op == bin16_pkg::DIV_OP && src_two == bin16_pkg::WORD_ZERO
            |=> operation_error_flag && !write_lo && !write_hi;
    endproperty
    a_div_zero: assert property (p_div_zero) else $error("zero divisor not flagged");

    property p_inc_wrap;
        ok_word && req_op == bin16_pkg::ADD_ONE_OP && dst_in == bin16_pkg::WORD_MAX_POS
            |=> result_lo == bin16_pkg::WORD_MAX_NEG;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap) else $error("increment wrap wrong");

    property p_dec_wrap;
        ok_word && req_op == bin16_pkg::SUB_ONE_OP && dst_in == bin16_pkg::WORD_MAX_NEG
            |=> result_lo == bin16_pkg::WORD_MAX_POS;
    endproperty
    a_dec_wrap: assert property (p_dec_wrap) else $error("decrement wrap wrong");

    property p_hold;
        !write_lo ##1 !write_lo |-> $stable(result_lo);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed without write");

    property p_pulse_once;
        req_valid && req_pulse && req_cond && $past(req_valid && req_pulse && req_cond)
            && req_slot == $past(req_slot) |=> !exec_done;
    endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("pulse form fired twice");

    property p_neg;
        ok_word && req_op == bin16_pkg::SIGN_FLIP_OP
            |=> result_lo == 16'(bin16_pkg::WORD_ZERO - $past(dst_in));
    endproperty
    a_neg: assert property (p_neg) else $error("sign flip wrong");

    // ****************************************************************
    // Further arithmetic checks
    // ****************************************************************
    property p_add_three;
        ok_word && req_op == bin16_pkg::ADD_THREE_OP
            |=> write_lo && result_lo == 16'($past(src_one) + $past(src_two));
    endproperty
    a_add_three: assert property (p_add_three) else $error("three-operand add wrong");

    property p_sub_two;
        ok_word && req_op == bin16_pkg::SUB_TWO_OP
            |=> write_lo && result_lo == 16'($past(dst_in) - $past(src_one));
    endproperty
    a_sub_two: assert property (p_sub_two) else $error("two-operand sub wrong");

    property p_inc;
        ok_word && req_op == bin16_pkg::ADD_ONE_OP
            |=> write_lo && result_lo == 16'($past(dst_in) + bin16_pkg::WORD_ONE);
    endproperty
    a_inc: assert property (p_inc) else $error("increment wrong");

    property p_dec;
        ok_word && req_op == bin16_pkg::SUB_ONE_OP
            |=> write_lo && result_lo == 16'($past(dst_in) - bin16_pkg::WORD_ONE);
    endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");

    property p_copy;
        ok_word && req_op == bin16_pkg::COPY_WORD_OP
            |=> write_lo && result_lo == $past(src_one);
    endproperty
    a_copy: assert property (p_copy) else $error("copy altered the word");

    // Division is checked by rebuilding the dividend, not by dividing again
    property p_div_rebuild;
        ok_word && req_op == bin16_pkg::DIV_OP
            |=> write_hi && 16'($signed(result_lo) * $signed($past(src_two))
                + $signed(result_hi)) == $past(src_one);
    endproperty
    a_div_rebuild: assert property (p_div_rebuild) else $error("division wrong");

    property p_rem_sign;
        ok_word && req_op == bin16_pkg::DIV_OP
            |=> result_hi == bin16_pkg::WORD_ZERO
                || result_hi[bin16_pkg::SIGN_BIT] == $past(src_one[bin16_pkg::SIGN_BIT]);
    endproperty
    a_rem_sign: assert property (p_rem_sign) else $error("remainder sign wrong");

    // ****************************************************************
    // Destination, error and execution checks
    // ****************************************************************
    // Only the digits named by the group may change in a bit destination
    property p_bits_merge;
        fire && !bad && dst_kind == bin16_pkg::DST_BITS
            |=> (result_lo >> (bin16_pkg::BITS_PER_DIGIT * $past(dst_digits)))
                == ($past(dst_in) >> (bin16_pkg::BITS_PER_DIGIT * $past(dst_digits)));
    endproperty
    a_bits_merge: assert property (p_bits_merge) else $error("bits above group changed");

    property p_bad_digits;
        fire && dst_kind == bin16_pkg::DST_BITS
            && (dst_digits == 3'h0 || dst_digits > bin16_pkg::FOUR_DIGIT_GROUP)
            |=> operation_error_flag && !write_lo;
    endproperty
    a_bad_digits: assert property (p_bad_digits) else $error("digit count accepted");

    property p_bad_kind;
        fire && dst_kind != bin16_pkg::DST_WORD && dst_kind != bin16_pkg::DST_BITS
            |=> operation_error_flag && !write_lo && !write_hi;
    endproperty
    a_bad_kind: assert property (p_bad_kind) else $error("bad destination accepted");

    // A new error wins over a clear in the same cycle
    property p_err_no_write;
        fire && bad |=> exec_done && operation_error_flag && !write_lo && !write_hi;
    endproperty
    a_err_no_write: assert property (p_err_no_write) else $error("wrote on error");

    property p_err_sticky;
        operation_error_flag && !error_clear |=> operation_error_flag;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

    property p_hi_hold;
        !write_hi |-> $stable(result_hi);
    endproperty
    a_hi_hold: assert property (p_hi_hold) else $error("high half changed");

    property p_level_fires;
        req_valid && req_cond && !req_pulse |=> exec_done;
    endproperty
    a_level_fires: assert property (p_level_fires) else $error("level form missed");

    property p_idle_quiet;
        (!req_valid || !req_cond) |=> !exec_done && !write_lo && !write_hi;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("output without request");

    c_div_word: cover property (ok_word && req_op == bin16_pkg::DIV_OP ##1 write_hi);
    c_error: cover property (fire && bad ##1 operation_error_flag);
    c_bits: cover property (fire && !bad && dst_kind == bin16_pkg::DST_BITS ##1 write_lo);
    c_pulse_blocked: cover property (req_valid && req_pulse && req_cond && !fire);
    c_inc_wrap: cover property (ok_word && req_op == bin16_pkg::ADD_ONE_OP
        && dst_in == bin16_pkg::WORD_MAX_POS);
endmodule

// file: logic/signed_div16.sv
`timescale 1ns/1ns

// ****************************************************************
// Shared constants and types
// ****************************************************************
package bin16_pkg;
    localparam int WORD_W = 16;
    localparam int PROD_W = 32;
    localparam int SIGN_BIT = 15;
    localparam int PROD_SIGN_BIT = 31;
    localparam int BITS_PER_DIGIT = 4;
    localparam logic [2:0] ONE_DIGIT_GROUP = 3'h1;
    localparam logic [2:0] FOUR_DIGIT_GROUP = 3'h4;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] WORD_ONE = 16'h0001;
    localparam logic [15:0] WORD_MAX_POS = 16'h7FFF;
    localparam logic [15:0] WORD_MAX_NEG = 16'h8000;
    localparam logic [15:0] WORD_ALL = 16'hFFFF;
    localparam int DEFAULT_SLOTS = 8;

    // Operation codes, one-hot
    typedef enum logic [9:0] {
        ADD_TWO_OP = 10'h001,
        ADD_THREE_OP = 10'h002,
        SUB_TWO_OP = 10'h004,
        SUB_THREE_OP = 10'h008,
        MUL_OP = 10'h010,
        DIV_OP = 10'h020,
        ADD_ONE_OP = 10'h040,
        SUB_ONE_OP = 10'h080,
        COPY_WORD_OP = 10'h100,
        SIGN_FLIP_OP = 10'h200
    } op_t;

    // Kind of destination operand
    typedef enum logic [2:0] {
        DST_WORD = 3'h1,
        DST_BITS = 3'h2,
        DST_BAD = 3'h4
    } dst_kind_t;
endpackage

// ****************************************************************
// Signed 16-bit divider
// ****************************************************************
module signed_div16 (
    // Operands
    input wire logic signed [15:0] dividend,
    input wire logic signed [15:0] divisor,
    // Results
    output logic signed [15:0] quotient,
    output logic signed [15:0] remainder,
    output logic div_zero
);
    // Truncates toward zero, so the remainder carries the dividend's sign
    always_comb begin
        div_zero = (divisor == bin16_pkg::WORD_ZERO);
        if (div_zero) begin
            quotient = bin16_pkg::WORD_ZERO;
            remainder = bin16_pkg::WORD_ZERO;
        end else begin
            quotient = dividend / divisor;
            remainder = dividend % divisor;
        end
    end
endmodule

// file: testbench/test_bin16_arith_move_unit.sv
`timescale 1ns/1ns

module test_bin16_arith_move_unit;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_pulse = 1'b0;
    logic req_cond = 1'b0;
    logic error_clear = 1'b0;
    bin16_pkg::op_t req_op = bin16_pkg::ADD_TWO_OP;
    bin16_pkg::dst_kind_t dst_kind = bin16_pkg::DST_WORD;
    logic [2:0] req_slot = 3'h0;
    logic [2:0] dst_digits = 3'h0;
    logic [15:0] src_one = 16'h0000;
    logic [15:0] src_two = 16'h0000;
    logic [15:0] dst_in = 16'h0000;
    logic [15:0] result_lo;
    logic [15:0] result_hi;
    logic write_lo;
    logic write_hi;
    logic exec_done;
    logic operation_error_flag;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int r;
    logic [15:0] exp_lo = 16'h0000;
    logic [15:0] exp_hi = 16'h0000;
    logic exp_flag = 1'b0;
    logic prev [8];

    bin16_arith_move_unit #(.SLOTS(8)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_op(req_op),
        .req_pulse(req_pulse), .req_cond(req_cond), .req_slot(req_slot),
        .src_one(src_one), .src_two(src_two), .dst_in(dst_in), .dst_kind(dst_kind),
        .dst_digits(dst_digits), .error_clear(error_clear), .result_lo(result_lo),
        .result_hi(result_hi), .write_lo(write_lo), .write_hi(write_hi),
        .exec_done(exec_done), .operation_error_flag(operation_error_flag)
    );

    always #50 clk = ~clk;

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 1300 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end

    // ****************************************************************
    // One instruction evaluation and its expectation
    // ****************************************************************
    // Reference result: product or {remainder, quotient} fill all 32 bits
    function automatic logic [31:0] model(input int n, input logic [15:0] a,
                                          input logic [15:0] b, input logic [15:0] d);
        logic signed [31:0] x, y, z;
        x = $signed(a);
        y = $signed(b);
        z = $signed(d);
        case (n)
            0: return z + x;
            1: return x + y;
            2: return z - x;
            3: return x - y;
            4: return x * y;
            5: return (y == 0) ? 32'h00000000 : {16'(x % y), 16'(x / y)};
            6: return z + 1;
            7: return z - 1;
            8: return x;
            default: return -z;
        endcase
    endfunction

    task automatic run(input int n, input logic p, input logic c, input logic [2:0] s,
                       input logic [15:0] a, input logic [15:0] b, input logic [15:0] d,
                       input logic [2:0] k, input logic [2:0] g);
        logic fire, err, wr, whi;
        logic [15:0] m;
        logic [31:0] v;
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= bin16_pkg::op_t'(10'h001 << n);
        req_pulse <= p;
        req_cond <= c;
        req_slot <= s;
        src_one <= a;
        src_two <= b;
        dst_in <= d;
        dst_kind <= bin16_pkg::dst_kind_t'(k);
        dst_digits <= g;
        fire = c && (!p || !prev[s]);
        prev[s] = c;
        err = fire && ((k != 3'h1 && !(k == 3'h2 && g >= 3'h1 && g <= 3'h4))
              || (n == 5 && b == 16'h0000));
        wr = fire && !err;
        whi = wr && k == 3'h1 && (n == 4 || n == 5);
        v = model(n, a, b, d);
        m = (k == 3'h2) ? 16'(16'hFFFF >> (16 - 4 * g)) : 16'hFFFF;
        if (wr) exp_lo = (d & ~m) | (v[15:0] & m);
        if (whi) exp_hi = v[31:16];
        if (err) exp_flag = 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        check("exec_done", {15'h0, exec_done}, {15'h0, fire});
        check("write_lo", {15'h0, write_lo}, {15'h0, wr});
        check("write_hi", {15'h0, write_hi}, {15'h0, whi});
        check("result_lo", result_lo, exp_lo);
        check("result_hi", result_hi, exp_hi);
        check("error_flag", {15'h0, operation_error_flag}, {15'h0, exp_flag});
        @(posedge clk);
        #1;
        check("exec_done idle", {15'h0, exec_done}, 16'h0000);
        check("result_lo held", result_lo, exp_lo);
    endtask

    task automatic cc(input int n, input logic [15:0] a, input logic [15:0] b,
                      input logic [15:0] d, input logic [2:0] k, input logic [2:0] g);
        run(n, 1'b0, 1'b1, 3'h0, a, b, d, k, g);
    endtask

    task automatic clear_err();
        @(posedge clk);
        error_clear <= 1'b1;
        @(posedge clk);
        error_clear <= 1'b0;
        #1;
        exp_flag = 1'b0;
        check("error_flag cleared", {15'h0, operation_error_flag}, 16'h0000);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        foreach (prev[i]) prev[i] = 1'b0;
        void'($urandom(36));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check("reset lo", result_lo, 16'h0000);
        check("reset flag", {15'h0, operation_error_flag}, 16'h0000);
        cc(0, 16'h0008, 16'h0000, 16'h0005, 3'h1, 3'h0);
        cc(1, 16'h7FFF, 16'h0001, 16'h1234, 3'h1, 3'h0);
        cc(2, 16'h0008, 16'h0000, 16'h0005, 3'h1, 3'h0);
        cc(3, 16'h8000, 16'h0001, 16'h0000, 3'h1, 3'h0);
        cc(4, 16'hFFFB, 16'h0003, 16'h0000, 3'h1, 3'h0);
        cc(4, 16'h162E, 16'h04D2, 16'h0000, 3'h1, 3'h0);
        cc(4, 16'hFFFB, 16'hFFFD, 16'hAAAA, 3'h2, 3'h1);
        cc(4, 16'h0123, 16'h0045, 16'h5555, 3'h2, 3'h4);
        cc(5, 16'hFFFB, 16'h0003, 16'h0000, 3'h1, 3'h0);
        cc(5, 16'h0005, 16'hFFFD, 16'h0000, 3'h1, 3'h0);
        cc(5, 16'hFFFB, 16'hFFFD, 16'h0000, 3'h1, 3'h0);
        cc(5, 16'h8000, 16'hFFFF, 16'h0000, 3'h1, 3'h0);
        cc(5, 16'h0064, 16'h0007, 16'hF0F0, 3'h2, 3'h3);
        cc(5, 16'h0064, 16'h0000, 16'h0000, 3'h1, 3'h0);
        cc(0, 16'h0001, 16'h0000, 16'h0001, 3'h4, 3'h0);
        cc(8, 16'h0001, 16'h0000, 16'h0001, 3'h0, 3'h0);
        cc(8, 16'h0001, 16'h0000, 16'h0001, 3'h2, 3'h0);
        cc(8, 16'h0001, 16'h0000, 16'h0001, 3'h2, 3'h5);
        clear_err();
        cc(6, 16'h0000, 16'h0000, 16'h7FFF, 3'h1, 3'h0);
        cc(7, 16'h0000, 16'h0000, 16'h8000, 3'h1, 3'h0);
        cc(8, 16'hBEEF, 16'h0000, 16'h0000, 3'h1, 3'h0);
        cc(9, 16'h0000, 16'h0000, 16'h0005, 3'h1, 3'h0);
        cc(9, 16'h0000, 16'h0000, 16'h8000, 3'h1, 3'h0);
        $display("test corners done");
        run(6, 1'b1, 1'b1, 3'h3, 16'h0000, 16'h0000, 16'h0010, 3'h1, 3'h0);
        run(6, 1'b1, 1'b1, 3'h3, 16'h0000, 16'h0000, 16'h0020, 3'h1, 3'h0);
        run(6, 1'b1, 1'b0, 3'h3, 16'h0000, 16'h0000, 16'h0030, 3'h1, 3'h0);
        run(6, 1'b1, 1'b1, 3'h3, 16'h0000, 16'h0000, 16'h0040, 3'h1, 3'h0);
        run(7, 1'b0, 1'b1, 3'h3, 16'h0000, 16'h0000, 16'h0050, 3'h1, 3'h0);
        run(7, 1'b0, 1'b1, 3'h3, 16'h0000, 16'h0000, 16'h0060, 3'h1, 3'h0);
        // Two pulse requests on back-to-back cycles: only the first may fire
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= bin16_pkg::ADD_ONE_OP;
        req_pulse <= 1'b1;
        req_cond <= 1'b1;
        req_slot <= 3'h5;
        dst_in <= 16'h0070;
        dst_kind <= bin16_pkg::DST_WORD;
        @(posedge clk);
        #1;
        check("pulse first", {15'h0, exec_done}, 16'h0001);
        check("pulse result", result_lo, 16'h0071);
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        check("pulse repeat", {15'h0, exec_done}, 16'h0000);
        prev[5] = 1'b1;
        exp_lo = 16'h0071;
        $display("test pulse done");
        for (int i = 0; i < 400; i++) begin
            if (i % 50 == 49) clear_err();
            r = $urandom % 8;
            run($urandom % 10, $urandom % 4 == 0, $urandom % 8 != 0, 3'($urandom),
                16'($urandom), (r == 0) ? 16'h0000 : 16'($urandom), 16'($urandom),
                (r < 5) ? 3'h1 : (r < 7) ? 3'h2 : 3'h4, 3'($urandom));
        end
        $display("test random done");
        finish_test();
    end
endmodule
